//--- hdl/srg_buf2.v
// Two-entry byte buffer with valid/ready on both sides and a flush
`timescale 1ns/10ps
`include "srg_defines.vh"
module srg_buf2 (
   input wire mclk,
   input wire reset,
   input wire flush,
   input wire in_valid,
   output wire in_ready,
   input wire [7:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [7:0] out_data
);
   reg [7:0] e0_q;
   reg [7:0] e1_q;
   reg [1:0] cnt_q;
   wire push;
   wire pop;

   assign in_ready = (cnt_q != `SRG_BUF_DEPTH);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data = e0_q;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge mclk) begin
      if (reset || flush) begin
         cnt_q <= 2'h0;
         e0_q <= 8'h00;
         e1_q <= 8'h00;
      end else begin
         case ({push, pop})
            2'b10: begin
               if (cnt_q == 2'h0) e0_q <= in_data;
               else e1_q <= in_data;
               cnt_q <= cnt_q + 2'h1;
            end
            2'b01: begin
               e0_q <= e1_q;
               cnt_q <= cnt_q - 2'h1;
            end
            2'b11: begin
               // With two held, entry one moves up while the new byte fills behind it; with one held, the new byte replaces entry zero
               if (cnt_q == 2'h1) e0_q <= in_data;
               else begin
                  e0_q <= e1_q;
                  e1_q <= in_data;
               end
            end
            default: cnt_q <= cnt_q;
         endcase
      end
   end
endmodule

//--- hdl/srg_defines.vh
// Shared constants for the serial read path and manual reset gate
`ifndef SRG_DEFINES_VH
`define SRG_DEFINES_VH
`define SRG_CLK_HZ 25000000
`define SRG_MR_TIME_MS 200
`define SRG_MR_CYCLES (`SRG_MR_TIME_MS * (`SRG_CLK_HZ / 1000))
`define SRG_MR_CNT_W 23
`define SRG_ADDR_W 11
`define SRG_ADDR_LAST 11'h7FF
`define SRG_DEV_CODE 4'hA
`define SRG_DEV_CODE_MSB 7
`define SRG_DEV_CODE_LSB 4
`define SRG_HI_MSB 3
`define SRG_HI_LSB 1
`define SRG_RW_BIT 0
`define SRG_BUF_DEPTH 2
`define SRG_SYNC_N 4
`define SRG_IN_SCL 0
`define SRG_IN_SDA 1
`define SRG_IN_RSTH 2
`define SRG_IN_RSTL 3
`define SRG_PIN_IDLE 4'hB
`endif

//--- hdl/srg_top.v
// Two-wire streaming read slave with manual reset timer and memory gate
`timescale 1ns/10ps
`include "srg_defines.vh"
// Contract
// - Each controller acknowledge after a byte makes the device send another byte.
// - Streamed bytes come from ascending consecutive locations, N then N+1.
// - Read address counter increments across all eleven bits.
// - Passing location 2047 the counter rolls over and data keeps flowing.
// - Both reset pins also accept an external level as manual reset.
// - Only the asserting edge of each manual reset pin is sensed; the access gate also senses the held pin level.
// - That edge starts a 200 ms count holding the complementary output active.
// - Complementary output releases at count end however long input is held.
// - Memory stays disabled while any reset condition is on either pin; only received bytes are gated, so a running read keeps streaming.
// - While manual input stays held past timeout, no access is acknowledged.
// - Missing controller acknowledge ends the read; device releases and waits STOP.
// - After rollover the counter continues from location 0.
// - Address byte is 1010, three high address bits, then read/write bit.
module srg_top #(
   parameter MR_CYCLES = `SRG_MR_CYCLES
) (
   input wire mclk,
   input wire reset,
   input wire scl_i,
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe,
   input wire rsth_i,
   output wire rsth_o,
   output wire rsth_oe,
   input wire rstl_n_i,
   output wire rstl_n_o,
   output wire rstl_n_oe,
   output reg [`SRG_ADDR_W-1:0] mem_addr,
   output reg mem_rd,
   input wire [7:0] mem_rdata
);
   localparam S_IDLE = 6'b000001;
   localparam S_RX = 6'b000010;
   localparam S_ACK = 6'b000100;
   localparam S_TX = 6'b001000;
   localparam S_MACK = 6'b010000;
   localparam S_WAIT = 6'b100000;

   // Idle level per pin: the active-high reset pin rests low, the rest high
   localparam [`SRG_SYNC_N-1:0] PIN_IDLE = `SRG_PIN_IDLE;
   wire [`SRG_SYNC_N-1:0] pin_raw;
   reg [`SRG_SYNC_N-1:0] s1_q;
   reg [`SRG_SYNC_N-1:0] s2_q;
   reg [`SRG_SYNC_N-1:0] s3_q;
   reg [`SRG_SYNC_N-1:0] lvl_q;
   reg [`SRG_SYNC_N-1:0] lvl_prev_q;
   wire [`SRG_SYNC_N-1:0] rise;
   wire [`SRG_SYNC_N-1:0] fall;

   assign pin_raw = {rstl_n_i, rsth_i, sda_i, scl_i};

   // Three stages; a level is accepted only when stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < `SRG_SYNC_N; gi = gi + 1) begin : g_sync
         always @(posedge mclk) begin
            if (reset) begin
               s1_q[gi] <= PIN_IDLE[gi];
               s2_q[gi] <= PIN_IDLE[gi];
               s3_q[gi] <= PIN_IDLE[gi];
               lvl_q[gi] <= PIN_IDLE[gi];
               lvl_prev_q[gi] <= PIN_IDLE[gi];
            end else begin
               s1_q[gi] <= pin_raw[gi];
               s2_q[gi] <= s1_q[gi];
               s3_q[gi] <= s2_q[gi];
               if (s2_q[gi] == s3_q[gi]) lvl_q[gi] <= s3_q[gi];
               lvl_prev_q[gi] <= lvl_q[gi];
            end
         end
         assign rise[gi] = lvl_q[gi] & ~lvl_prev_q[gi];
         assign fall[gi] = ~lvl_q[gi] & lvl_prev_q[gi];
      end
   endgenerate

   // Manual reset timer
   reg [`SRG_MR_CNT_W-1:0] mr_cnt_q;
   reg drv_l_q;
   reg drv_h_q;
   wire mr_busy;
   wire ext_h;
   wire ext_l;
   wire blocked;

   assign mr_busy = drv_l_q | drv_h_q;
   // A pin we drive ourselves is not taken as a manual input
   assign ext_h = lvl_q[`SRG_IN_RSTH] & ~drv_h_q;
   assign ext_l = ~lvl_q[`SRG_IN_RSTL] & ~drv_l_q;
   assign blocked = mr_busy | ext_h | ext_l;

   always @(posedge mclk) begin
      if (reset) begin
         mr_cnt_q <= {`SRG_MR_CNT_W{1'b0}};
         drv_l_q <= 1'b0;
         drv_h_q <= 1'b0;
      end else if (!mr_busy && rise[`SRG_IN_RSTH]) begin
         drv_l_q <= 1'b1;
         mr_cnt_q <= MR_CYCLES[`SRG_MR_CNT_W-1:0] - {{(`SRG_MR_CNT_W-1){1'b0}}, 1'b1};
      end else if (!mr_busy && fall[`SRG_IN_RSTL]) begin
         drv_h_q <= 1'b1;
         mr_cnt_q <= MR_CYCLES[`SRG_MR_CNT_W-1:0] - {{(`SRG_MR_CNT_W-1){1'b0}}, 1'b1};
      end else if (mr_busy) begin
         if (mr_cnt_q == {`SRG_MR_CNT_W{1'b0}}) begin
            // Release does not wait for the manual input to go away
            drv_l_q <= 1'b0;
            drv_h_q <= 1'b0;
         end else begin
            mr_cnt_q <= mr_cnt_q - {{(`SRG_MR_CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   assign rsth_o = 1'b1;
   assign rsth_oe = drv_h_q;
   assign rstl_n_o = 1'b0;
   assign rstl_n_oe = drv_l_q;

   // Bus conditions from the filtered lines
   wire scl_h;
   wire scl_rise;
   wire scl_fall;
   wire bus_start;
   wire bus_stop;
   wire sda_l;
   assign scl_h = lvl_q[`SRG_IN_SCL];
   assign sda_l = lvl_q[`SRG_IN_SDA];
   assign scl_rise = rise[`SRG_IN_SCL];
   assign scl_fall = fall[`SRG_IN_SCL];
   assign bus_start = scl_h & lvl_prev_q[`SRG_IN_SCL] & fall[`SRG_IN_SDA];
   assign bus_stop = scl_h & lvl_prev_q[`SRG_IN_SCL] & rise[`SRG_IN_SDA];

   // Prefetch into the buffer so the next byte is ready at the ack edge
   reg [`SRG_ADDR_W-1:0] addr_q;
   reg [`SRG_ADDR_W-1:0] fetch_q;
   reg inflight_q;
   reg prefetch_q;
   reg flush_q;
   wire buf_ready;
   wire buf_valid;
   wire [7:0] buf_data;
   reg pop;

   srg_buf2 u_buf (
      .mclk(mclk),
      .reset(reset),
      .flush(flush_q),
      .in_valid(inflight_q),
      .in_ready(buf_ready),
      .in_data(mem_rdata),
      .out_valid(buf_valid),
      .out_ready(pop),
      .out_data(buf_data)
   );

   always @(posedge mclk) begin
      if (reset || flush_q) begin
         mem_rd <= 1'b0;
         inflight_q <= 1'b0;
         mem_addr <= addr_q;
         fetch_q <= addr_q;
      end else begin
         inflight_q <= mem_rd;
         // One read in flight at most, so a granted slot is never overrun
         mem_rd <= prefetch_q & buf_ready & ~mem_rd & ~inflight_q;
         if (prefetch_q & buf_ready & ~mem_rd & ~inflight_q) begin
            mem_addr <= fetch_q;
            fetch_q <= fetch_q + {{(`SRG_ADDR_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // Protocol state machine
   reg [5:0] st_q;
   reg [7:0] sh_q;
   reg [2:0] bit_q;
   reg first_q;
   reg word_q;
   reg rd_q;
   reg acked_q;
   reg [2:0] hi_q;
   reg rx_full_q;

   always @* begin
      pop = 1'b0;
      if (scl_fall && !bus_start && !bus_stop) begin
         if ((st_q == S_ACK && rd_q) || (st_q == S_MACK && acked_q)) pop = 1'b1;
      end
   end

   always @(posedge mclk) begin
      if (reset) begin
         st_q <= S_IDLE;
         sh_q <= 8'h00;
         bit_q <= 3'h0;
         first_q <= 1'b0;
         word_q <= 1'b0;
         rd_q <= 1'b0;
         acked_q <= 1'b0;
         hi_q <= 3'h0;
         rx_full_q <= 1'b0;
         addr_q <= {`SRG_ADDR_W{1'b0}};
         sda_o <= 1'b0;
         sda_oe <= 1'b0;
         prefetch_q <= 1'b0;
         flush_q <= 1'b0;
      end else begin
         flush_q <= 1'b0;
         if (bus_start) begin
            st_q <= S_RX;
            bit_q <= 3'h0;
            first_q <= 1'b1;
            rx_full_q <= 1'b0;
            sda_oe <= 1'b0;
            prefetch_q <= 1'b0;
         end else if (bus_stop) begin
            st_q <= S_IDLE;
            sda_oe <= 1'b0;
            prefetch_q <= 1'b0;
         end else begin
            case (st_q)
               S_RX: begin
                  if (scl_rise) begin
                     sh_q <= {sh_q[6:0], sda_l};
                     bit_q <= bit_q + 3'h1;
                     if (bit_q == 3'h7) rx_full_q <= 1'b1;
                  end else if (scl_fall && rx_full_q) begin
                     // Bit count wraps, so the clock fall after START must not pass as a byte
                     rx_full_q <= 1'b0;
                     first_q <= 1'b0;
                     if (blocked) begin
                        st_q <= S_IDLE;
                     end else if (first_q) begin
                        if (sh_q[`SRG_DEV_CODE_MSB:`SRG_DEV_CODE_LSB] == `SRG_DEV_CODE) begin
                           st_q <= S_ACK;
                           sda_oe <= 1'b1;
                           rd_q <= sh_q[`SRG_RW_BIT];
                           word_q <= 1'b1;
                           hi_q <= sh_q[`SRG_HI_MSB:`SRG_HI_LSB];
                           if (sh_q[`SRG_RW_BIT]) begin
                              // Reads continue from the counter; refill from it
                              flush_q <= 1'b1;
                              prefetch_q <= 1'b1;
                           end
                        end else begin
                           st_q <= S_IDLE;
                        end
                     end else begin
                        // Write data is outside this block; only the word address lands
                        if (word_q) addr_q <= {hi_q, sh_q};
                        word_q <= 1'b0;
                        st_q <= S_ACK;
                        sda_oe <= 1'b1;
                     end
                  end
               end
               S_ACK: begin
                  if (scl_fall) begin
                     bit_q <= 3'h0;
                     if (rd_q) begin
                        st_q <= S_TX;
                        sh_q <= {buf_data[6:0], 1'b0};
                        sda_oe <= ~buf_data[7];
                        addr_q <= addr_q + {{(`SRG_ADDR_W-1){1'b0}}, 1'b1};
                     end else begin
                        st_q <= S_RX;
                        sda_oe <= 1'b0;
                     end
                  end
               end
               S_TX: begin
                  if (scl_fall) begin
                     bit_q <= bit_q + 3'h1;
                     if (bit_q == 3'h7) begin
                        st_q <= S_MACK;
                        sda_oe <= 1'b0;
                     end else begin
                        sda_oe <= ~sh_q[7];
                        sh_q <= {sh_q[6:0], 1'b0};
                     end
                  end
               end
               S_MACK: begin
                  if (scl_rise) acked_q <= ~sda_l;
                  if (scl_fall) begin
                     bit_q <= 3'h0;
                     if (acked_q) begin
                        st_q <= S_TX;
                        sh_q <= {buf_data[6:0], 1'b0};
                        sda_oe <= ~buf_data[7];
                        // Eleven-bit wrap takes location 2047 back to 0
                        addr_q <= addr_q + {{(`SRG_ADDR_W-1){1'b0}}, 1'b1};
                     end else begin
                        st_q <= S_WAIT;
                        prefetch_q <= 1'b0;
                     end
                  end
               end
               S_WAIT: begin
                  sda_oe <= 1'b0;
               end
               default: begin
                  sda_oe <= 1'b0;
                  st_q <= S_IDLE;
               end
            endcase
         end
      end
   end
endmodule

//--- sim/srg_chk_monitor.sv
// Port checker for the streaming read slave and manual reset timer
`timescale 1ns/10ps
module srg_chk #(
   parameter MR_CYCLES = 200
) (
   input wire mclk,
   input wire reset,
   input wire rsth_i,
   input wire rstl_n_i,
   input wire sda_o,
   input wire sda_oe,
   input wire rsth_oe,
   input wire rstl_n_oe,
   input wire mem_rd
);
   reg [31:0] hc_q;
   reg [31:0] lc_q;
   // Counts how many cycles each complementary output has stood active
   always @(posedge mclk) begin
      hc_q <= (reset || !rstl_n_oe) ? 32'h0 : hc_q + 32'h1;
      lc_q <= (reset || !rsth_oe) ? 32'h0 : lc_q + 32'h1;
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   a_pin_levels: assert property (!sda_o && (!rsth_oe || rsth_i) && (!rstl_n_oe || !rstl_n_i))
      else $error("pin drive level wrong");
   a_hi_len: assert property ($fell(rstl_n_oe) |-> hc_q == MR_CYCLES)
      else $error("low output pulse length wrong");
   a_lo_len: assert property ($fell(rsth_oe) |-> lc_q == MR_CYCLES)
      else $error("high output pulse length wrong");
   a_timer_max: assert property (hc_q <= MR_CYCLES && lc_q <= MR_CYCLES)
      else $error("reset output held too long");
   a_hi_cause: assert property ($rose(rstl_n_oe) |-> $past(rsth_i) && !rsth_oe)
      else $error("low output without high pin edge");
   a_lo_cause: assert property ($rose(rsth_oe) |-> !$past(rstl_n_i) && !rstl_n_oe)
      else $error("high output without low pin edge");
   a_one_timer: assert property (!(rsth_oe && rstl_n_oe))
      else $error("both reset outputs driven");
   a_mem_pulse: assert property (mem_rd |=> !mem_rd)
      else $error("back to back memory read");
   a_ack_hold: assert property ($rose(sda_oe) |=> sda_oe [*3])
      else $error("data line pull too short");
   a_gate_pins: assert property ($rose(sda_oe) |-> rstl_n_i && !rsth_i)
      else $error("bus answered during reset");
endmodule

bind srg_top srg_chk #(.MR_CYCLES(MR_CYCLES)) u_chk (
   .mclk(mclk),
   .reset(reset),
   .rsth_i(rsth_i),
   .rstl_n_i(rstl_n_i),
   .sda_o(sda_o),
   .sda_oe(sda_oe),
   .rsth_oe(rsth_oe),
   .rstl_n_oe(rstl_n_oe),
   .mem_rd(mem_rd)
);

//--- sim/srg_ctl.sv
// Two-wire bus controller model, eight mclk per bit
`timescale 1ns/10ps
module srg_ctl (
   input wire mclk,
   input wire sda_w,
   output reg scl = 1'b1,
   output reg sda_m = 1'b1
);
   task tick(input integer n);
      repeat (n) @(posedge mclk);
   endtask
   // Expects an idle bus; clock stands high between frames
   task start;
      begin
         sda_m <= 1'b0;
         tick(4);
         scl <= 1'b0;
         tick(4);
      end
   endtask
   task stop;
      begin
         sda_m <= 1'b0;
         tick(4);
         scl <= 1'b1;
         tick(4);
         sda_m <= 1'b1;
         tick(8);
      end
   endtask
   // Long low phase: the slave's filtered view must see its own data settle before the rise
   task bit_x(input b, output s);
      begin
         sda_m <= b;
         tick(5);
         scl <= 1'b1;
         tick(2);
         s = sda_w;
         scl <= 1'b0;
         tick(1);
      end
   endtask
   task xfer(input [7:0] b, input ackin, output [7:0] r, output ack);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1)
            bit_x(b[i], r[i]);
         bit_x(ackin, ack);
         sda_m <= 1'b1;
         tick(1);
      end
   endtask
endmodule

//--- sim/test_seq_read_manual_reset_gate.sv
// Self-checking bench for the streaming read slave and reset gate
`timescale 1ns/10ps
module test_seq_read_manual_reset_gate;
   localparam MR = 200;
   reg mclk = 1'b0;
   reg reset = 1'b1;
   reg ext_h = 1'b0;
   reg ext_l_n = 1'b1;
   reg [7:0] mem_rdata = 8'h00;
   reg [10:0] nxt = 11'h000;
   integer error_cnt = 0;
   integer num_checks = 0;
   wire scl, sda_m, sda_w, sda_o, sda_oe, rsth_o, rsth_oe, rstl_n_o, rstl_n_oe, mem_rd;
   wire [10:0] mem_addr;
   wire rsth_w = rsth_oe ? rsth_o : ext_h;
   wire rstl_w = rstl_n_oe ? rstl_n_o : ext_l_n;
   assign sda_w = sda_m & (sda_oe ? sda_o : 1'b1);
   initial begin
      forever #20 mclk = ~mclk;
   end
   srg_top #(.MR_CYCLES(MR)) DUT (.mclk(mclk), .reset(reset), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe(sda_oe), .rsth_i(rsth_w), .rsth_o(rsth_o), .rsth_oe(rsth_oe), .rstl_n_i(rstl_w),
      .rstl_n_o(rstl_n_o), .rstl_n_oe(rstl_n_oe), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
   srg_ctl c (.mclk(mclk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
   function [7:0] pat(input [10:0] a);
      pat = a[7:0] ^ {a[10:8], 5'h0B};
   endfunction
   // Data is only valid the cycle after a read strobe; garbage otherwise
   always @(posedge mclk)
      mem_rdata <= mem_rd ? pat(mem_addr) : ~mem_rdata;
   task chk(input string nm, input [7:0] e, input [7:0] g);
      begin
         num_checks = num_checks + 1;
         if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task addr_ack(input [7:0] b, input ek);
      reg [7:0] r;
      reg k;
      begin
         c.start;
         c.xfer(b, 1'b1, r, k);
         chk("ack", {7'h0, ek}, {7'h0, k});
      end
   endtask
   task rd_last;
      reg [7:0] r;
      reg k;
      begin
         c.xfer(8'hFF, 1'b1, r, k);
         chk("data", pat(nxt), r);
         nxt = nxt + 11'h1;
         c.tick(6);
         chk("release", 8'h00, {7'h0, sda_oe});
         c.stop;
      end
   endtask
   task t_seq(input [2:0] hi, input [7:0] w, input integer n);
      reg [7:0] r;
      reg k;
      integer i;
      begin
         addr_ack({4'hA, hi, 1'b0}, 1'b0);
         c.xfer(w, 1'b1, r, k);
         chk("word ack", 8'h00, {7'h0, k});
         c.stop;
         nxt = {hi, w};
         addr_ack({4'hA, ~hi, 1'b1}, 1'b0);
         for (i = 1; i < n; i = i + 1) begin
            c.xfer(8'hFF, 1'b0, r, k);
            chk("data", pat(nxt), r);
            nxt = nxt + 11'h1;
         end
         rd_last;
      end
   endtask
   task t_cur;
      begin
         addr_ack(8'hA1, 1'b0);
         rd_last;
      end
   endtask
   task t_mr_h;
      begin
         ext_h <= 1'b1;
         c.tick(20);
         ext_h <= 1'b0;
         c.tick(10);
         chk("low out on", 8'h01, {7'h0, rstl_n_oe});
         addr_ack(8'hA1, 1'b1);
         c.stop;
         c.tick(MR);
         chk("low out off", 8'h00, {7'h0, rstl_n_oe});
         t_cur;
      end
   endtask
   task t_mr_l;
      begin
         ext_l_n <= 1'b0;
         c.tick(10);
         chk("high out on", 8'h01, {7'h0, rsth_oe});
         c.tick(MR + 20);
         chk("high out off", 8'h00, {7'h0, rsth_oe});
         addr_ack(8'hA1, 1'b1);
         c.stop;
         ext_l_n <= 1'b1;
         c.tick(20);
         chk("no retrigger", 8'h00, {7'h0, rsth_oe});
         t_cur;
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d errors %0d", num_checks, error_cnt);
         if (error_cnt == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      c.tick(10);
      t_seq(3'h7, 8'hFE, 4);
      t_seq(3'h0, 8'hFF, 3);
      t_cur;
      addr_ack(8'hB1, 1'b1);
      c.stop;
      t_mr_h;
      t_mr_l;
      give_verdict;
   end
   initial begin
      #2000000;
      error_cnt = error_cnt + 1;
      give_verdict;
   end
endmodule
